// ---- logic/fault_select_pkg.sv ----
// constants and types for the fault reset and event selection bank
package fault_select_pkg;
  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] COMM_FAULT_RESET_SELECT_IDX = 16'h042b;
  localparam logic [15:0] SUPPLY_FAULT_EVENT_SELECT_0_IDX = 16'h0430;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] COMM_FAULT_RESET_SELECT_ADDR = ADDR_W'(COMM_FAULT_RESET_SELECT_IDX * 4);
  localparam logic [ADDR_W-1:0] SUPPLY_FAULT_EVENT_SELECT_0_ADDR =
    ADDR_W'(SUPPLY_FAULT_EVENT_SELECT_0_IDX * 4);
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int COMM_TIMEOUT_RESET_POS = 3;
  localparam int ERROR_COUNTER_OVERFLOW_RESET_POS = 2;
  localparam logic COMM_TIMEOUT_RESET_RST = 1'b1;
  localparam logic ERROR_COUNTER_OVERFLOW_RESET_RST = 1'b0;
  localparam int NUM_SUPPLY_FAULTS = 12;
  localparam logic [NUM_SUPPLY_FAULTS-1:0] SUPPLY_EVENT_RST = 12'h000;
  // supply fault bit positions
  localparam int CORE_SUPPLY_UNDER_POS = 11;
  localparam int CORE_SUPPLY_OVER_POS = 10;
  localparam int AUX_SUPPLY_UNDER_POS = 9;
  localparam int AUX_SUPPLY_OVER_POS = 8;
  localparam int PREREG_REFERENCE_UNDER_POS = 7;
  localparam int CHARGE_PUMP_UNDER_POS = 6;
  localparam int CHARGE_PUMP_OVER_POS = 5;
  localparam int ANALOG_SUPPLY_UNDER_POS = 4;
  localparam int ANALOG_SUPPLY_OVER_POS = 3;
  localparam int ANALOG_CORE_UNDER_POS = 2;
  localparam int ANALOG_CORE_OVER_POS = 1;
  localparam int BATTERY_OVER_POS = 0;
  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic comm_timeout_reset_bit;
    logic error_counter_overflow_reset_bit;
  } comm_reset_cfg_t;
  typedef logic [NUM_SUPPLY_FAULTS-1:0] supply_vec_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_t;
endpackage : fault_select_pkg

// ---- logic/supply_event_gate.sv ----
// per-fault event gating and detection status for the supply monitors
`timescale 1ns/1ps
`default_nettype none
module supply_event_gate
  import fault_select_pkg::*;
(
  // clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // faults and enables
  input wire supply_vec_t fault_in,
  input wire supply_vec_t event_enable,
  // results
  output supply_vec_t event_out,
  output supply_vec_t fault_seen
);
  supply_vec_t event_q;
  supply_vec_t seen_q;

  // ---------------------------------------------------------------
  // one gate per supply fault
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_SUPPLY_FAULTS; i++) begin : g_fault
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        event_q[i] <= 1'b0;
      end else if (ce) begin
        event_q[i] <= fault_in[i] & event_enable[i];
      end
    end
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        seen_q[i] <= 1'b0;
      end else if (ce) begin
        seen_q[i] <= fault_in[i];
      end
    end
  end

  assign event_out = event_q;
  assign fault_seen = seen_q;
endmodule : supply_event_gate
`default_nettype wire

// ---- logic/fault_reset_event_select.sv ----
// fault reset and event selection register bank with axi4-lite slave
//
// Overview of operation
// - timeout reset bit 3, resets to 1: comm timeout forces power-on reset
// - timeout reset bit 0: comm timeout returns device to previous mode
// - overflow bit 2, resets to 0: error counter at maximum forces reset
// - comm bits 15:4, 1:0 and event bits 15:12 read zero, read-only
// - bit 11 core supply under-voltage event enable, resets to 0
// - bit 10 core supply over-voltage event enable, resets to 0
// - bit 9 auxiliary supply under-voltage event enable, resets to 0
// - bit 8 auxiliary supply over-voltage event enable, resets to 0
// - bit 7 pre-regulator reference under-voltage event enable, resets to 0
// - bit 6 charge pump under-voltage event enable, resets to 0
// - bit 5 charge pump over-voltage event enable, resets to 0
// - bits 4:0 analog, analog core, battery event enables, reset to 0
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module fault_reset_event_select
  import fault_select_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fault monitors
  input wire logic comm_timeout,
  input wire logic error_counter_max,
  input wire supply_vec_t supply_fault,
  // actions
  output logic por_request,
  output logic fallback_previous_mode,
  output supply_vec_t supply_event,
  output supply_vec_t supply_fault_seen
);
  comm_reset_cfg_t comm_cfg_q;
  supply_vec_t event_en_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  rd_state_t rd_state_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic por_q;
  logic fallback_q;
  logic do_write;
  logic wr_comm;
  logic wr_event;
  logic [15:0] comm_read;
  logic [15:0] event_read;

  // ---------------------------------------------------------------
  // write channels
  // ---------------------------------------------------------------
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready = ~w_have_q & ~bvalid_q;
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_comm = do_write && (awaddr_q == COMM_FAULT_RESET_SELECT_ADDR);
  assign wr_event = do_write && (awaddr_q == SUPPLY_FAULT_EVENT_SELECT_0_ADDR);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_comm || wr_event) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      comm_cfg_q.comm_timeout_reset_bit <= COMM_TIMEOUT_RESET_RST;
      comm_cfg_q.error_counter_overflow_reset_bit <= ERROR_COUNTER_OVERFLOW_RESET_RST;
    end else if (ce && wr_comm && wstrb_q[0]) begin
      comm_cfg_q.comm_timeout_reset_bit <= wdata_q[COMM_TIMEOUT_RESET_POS];
      comm_cfg_q.error_counter_overflow_reset_bit <= wdata_q[ERROR_COUNTER_OVERFLOW_RESET_POS];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      event_en_q <= SUPPLY_EVENT_RST;
    end else if (ce && wr_event) begin
      if (wstrb_q[0]) begin
        event_en_q[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        event_en_q[11:8] <= wdata_q[11:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_comb begin
    comm_read = 16'h0000;
    comm_read[COMM_TIMEOUT_RESET_POS] = comm_cfg_q.comm_timeout_reset_bit;
    comm_read[ERROR_COUNTER_OVERFLOW_RESET_POS] = comm_cfg_q.error_counter_overflow_reset_bit;
    event_read = {4'h0, event_en_q};
  end

  assign s_axi_arready = (rd_state_q == RD_IDLE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_state_q <= RD_IDLE;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      unique case (rd_state_q)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_q <= RD_RESP;
            if (s_axi_araddr == COMM_FAULT_RESET_SELECT_ADDR) begin
              rdata_q <= {16'h0000, comm_read};
              rresp_q <= RESP_OKAY;
            end else if (s_axi_araddr == SUPPLY_FAULT_EVENT_SELECT_0_ADDR) begin
              rdata_q <= {16'h0000, event_read};
              rresp_q <= RESP_OKAY;
            end else begin
              rdata_q <= 32'h0000_0000;
              rresp_q <= RESP_SLVERR;
            end
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_q <= RD_IDLE;
          end
        end
        default: begin
          rd_state_q <= RD_IDLE;
        end
      endcase
    end
  end

  assign s_axi_rvalid = (rd_state_q == RD_RESP);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ---------------------------------------------------------------
  // communication fault actions
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      por_q <= 1'b0;
    end else if (ce) begin
      por_q <= (comm_timeout & comm_cfg_q.comm_timeout_reset_bit)
        | (error_counter_max & comm_cfg_q.error_counter_overflow_reset_bit);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fallback_q <= 1'b0;
    end else if (ce) begin
      fallback_q <= comm_timeout & ~comm_cfg_q.comm_timeout_reset_bit;
    end
  end

  assign por_request = por_q;
  assign fallback_previous_mode = fallback_q;

  // ---------------------------------------------------------------
  // supply fault events
  // ---------------------------------------------------------------
  supply_event_gate u_gate (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .fault_in(supply_fault),
    .event_enable(event_en_q),
    .event_out(supply_event),
    .fault_seen(supply_fault_seen)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_timeout_por;
    @(posedge sys_clk) disable iff (rst)
    ce && comm_timeout && comm_cfg_q.comm_timeout_reset_bit |=> por_request && !fallback_previous_mode;
  endproperty
  a_timeout_por: assert property (p_timeout_por) else $error("timeout did not reset");

  property p_timeout_fallback;
    @(posedge sys_clk) disable iff (rst)
    ce && comm_timeout && !comm_cfg_q.comm_timeout_reset_bit |=> fallback_previous_mode;
  endproperty
  a_timeout_fallback: assert property (p_timeout_fallback) else $error("no fallback");

  property p_overflow_por;
    @(posedge sys_clk) disable iff (rst)
    ce && !comm_timeout |=>
      por_request == ($past(error_counter_max)
      && $past(comm_cfg_q.error_counter_overflow_reset_bit));
  endproperty
  a_overflow_por: assert property (p_overflow_por) else $error("overflow reset wrong");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (rst)
    s_axi_rvalid && s_axi_rresp == RESP_OKAY |-> s_axi_rdata[31:12] == 20'h00000
      && (s_axi_rdata[11:4] == 8'h00 || $past(s_axi_araddr) != COMM_FAULT_RESET_SELECT_ADDR
      || !$past(s_axi_arready))
      && (s_axi_rdata[1:0] == 2'h0 || $past(s_axi_araddr) != COMM_FAULT_RESET_SELECT_ADDR
      || !$past(s_axi_arready));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_reset_values;
    @(posedge sys_clk)
    rst |=> comm_cfg_q.comm_timeout_reset_bit && !comm_cfg_q.error_counter_overflow_reset_bit
      && event_en_q == 12'h000;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_event_gated;
    @(posedge sys_clk) disable iff (rst)
    ce |=> supply_event == ($past(supply_fault) & $past(event_en_q));
  endproperty
  a_event_gated: assert property (p_event_gated) else $error("event gating wrong");

  property p_no_event_disabled;
    @(posedge sys_clk) disable iff (rst)
    ce && !event_en_q[CHARGE_PUMP_OVER_POS] |=> !supply_event[CHARGE_PUMP_OVER_POS];
  endproperty
  a_no_event_disabled: assert property (p_no_event_disabled) else $error("event while off");

  property p_still_detected;
    @(posedge sys_clk) disable iff (rst)
    ce && supply_fault[CORE_SUPPLY_UNDER_POS] |=> supply_fault_seen[CORE_SUPPLY_UNDER_POS];
  endproperty
  a_still_detected: assert property (p_still_detected) else $error("fault not seen");

  property p_event_write;
    @(posedge sys_clk) disable iff (rst)
    ce && wr_event && wstrb_q == 4'hf |=>
      {20'h00000, event_en_q} == ($past(wdata_q) & 32'h0000_0fff) && s_axi_bvalid;
  endproperty
  a_event_write: assert property (p_event_write) else $error("enable write lost");

  c_por: cover property (@(posedge sys_clk) disable iff (rst) por_request);
  c_fallback: cover property (@(posedge sys_clk) disable iff (rst) fallback_previous_mode);
  c_event: cover property (@(posedge sys_clk) disable iff (rst) |supply_event);
  c_bad_read: cover property (@(posedge sys_clk) disable iff (rst)
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : fault_reset_event_select
`default_nettype wire

// ---- tb/fault_reset_event_select_tb.sv ----
// self-checking bench for the fault reset and event selection bank
`timescale 1ns/1ps
`default_nettype none
module fault_reset_event_select_tb
  import fault_select_pkg::*;
;
  // ---------------------------------------------------------------
  // clock, stimulus and design
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic comm_timeout = 1'b0;
  logic error_counter_max = 1'b0;
  supply_vec_t supply_fault = '0;
  logic por_request;
  logic fallback_previous_mode;
  supply_vec_t supply_event;
  supply_vec_t supply_fault_seen;
  int mismatches = 0;
  int tests_run = 0;

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  fault_reset_event_select dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comm_timeout(comm_timeout), .error_counter_max(error_counter_max),
    .supply_fault(supply_fault), .por_request(por_request),
    .fallback_previous_mode(fallback_previous_mode), .supply_event(supply_event),
    .supply_fault_seen(supply_fault_seen)
  );

  // ---------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t response %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  // ready is sampled 1 ns after an edge; it cannot change before the next edge
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hit, w_hit, done;
    int n;
    n = 0;
    done = 1'b0;
    r = 2'bxx;
    @(posedge sys_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    while (!done && n < 100) begin
      #1;
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      done = bvalid & bready;
      if (done) r = bresp;
      @(posedge sys_clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!done) chk_val(32'h0, 32'h1);
  endtask : axi_wr

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit, done;
    int n;
    n = 0;
    done = 1'b0;
    d = 'x;
    r = 'x;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done && n < 100) begin
      #1;
      ar_hit = arvalid & arready;
      done = rvalid & rready;
      if (done) begin
        d = rdata;
        r = rresp;
      end
      @(posedge sys_clk);
      if (ar_hit) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!done) chk_val(32'h0, 32'h1);
  endtask : axi_rd

  // one sampled fault cycle, outputs checked after the following edge
  task automatic pulse(input logic t, input logic e, input supply_vec_t f);
    @(posedge sys_clk);
    comm_timeout <= t; error_counter_max <= e; supply_fault <= f;
    @(posedge sys_clk);
    comm_timeout <= 1'b0; error_counter_max <= 1'b0; supply_fault <= '0;
    #1;
  endtask : pulse

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(COMM_FAULT_RESET_SELECT_ADDR, d, r);
    chk_val(d, 32'h0000_0008);
    chk_resp(r, RESP_OKAY);
    axi_rd(SUPPLY_FAULT_EVENT_SELECT_0_ADDR, d, r);
    chk_val(d, 32'h0000_0000);
    chk_resp(r, RESP_OKAY);
  endtask : t_reset_values

  // reset again after the registers were written
  task automatic t_mid_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_values();
  endtask : t_mid_reset

  task automatic t_reserved();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(COMM_FAULT_RESET_SELECT_ADDR, 32'hffff_ffff, r);
    chk_resp(r, RESP_OKAY);
    axi_rd(COMM_FAULT_RESET_SELECT_ADDR, d, r);
    chk_val(d, 32'h0000_000c);
    axi_wr(SUPPLY_FAULT_EVENT_SELECT_0_ADDR, 32'hffff_ffff, r);
    axi_rd(SUPPLY_FAULT_EVENT_SELECT_0_ADDR, d, r);
    chk_val(d, 32'h0000_0fff);
    axi_wr(16'h0100, 32'hffff_ffff, r);
    chk_resp(r, RESP_SLVERR);
    axi_rd(16'h0100, d, r);
    chk_resp(r, RESP_SLVERR);
    chk_val(d, 32'h0);
  endtask : t_reserved

  task automatic t_comm_faults();
    logic [1:0] r;
    axi_wr(COMM_FAULT_RESET_SELECT_ADDR, 32'h0000_0008, r);
    pulse(1'b1, 1'b0, '0);
    chk_val(por_request, 1'b1);
    chk_val(fallback_previous_mode, 1'b0);
    pulse(1'b0, 1'b1, '0);
    chk_val(por_request, 1'b0);
    axi_wr(COMM_FAULT_RESET_SELECT_ADDR, 32'h0000_0004, r);
    pulse(1'b1, 1'b0, '0);
    chk_val(fallback_previous_mode, 1'b1);
    chk_val(por_request, 1'b0);
    pulse(1'b0, 1'b1, '0);
    chk_val(por_request, 1'b1);
    chk_val(fallback_previous_mode, 1'b0);
    // clock enable low: a triggering cycle must leave every flop frozen
    @(posedge sys_clk);
    ce <= 1'b0;
    pulse(1'b0, 1'b1, 12'hfff);
    chk_val(por_request, 1'b0);
    chk_val(supply_fault_seen, 12'h000);
    @(posedge sys_clk);
    ce <= 1'b1;
  endtask : t_comm_faults

  task automatic t_supply_events();
    logic [1:0] r;
    axi_wr(SUPPLY_FAULT_EVENT_SELECT_0_ADDR, 32'h0, r);
    chk_resp(r, RESP_OKAY);
    pulse(1'b0, 1'b0, 12'hfff);
    chk_val(supply_event, 12'h000);
    chk_val(supply_fault_seen, 12'hfff);
    for (int i = 0; i < NUM_SUPPLY_FAULTS; i++) begin
      axi_wr(SUPPLY_FAULT_EVENT_SELECT_0_ADDR, 32'h1 << i, r);
      pulse(1'b0, 1'b0, 12'hfff);
      chk_val(supply_event, 12'h001 << i);
      chk_val(supply_fault_seen, 12'hfff);
      pulse(1'b0, 1'b0, ~(12'h001 << i));
      chk_val(supply_event, 12'h000);
    end
  endtask : t_supply_events

  // ---------------------------------------------------------------
  // sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_values();
    t_reserved();
    t_comm_faults();
    t_supply_events();
    t_mid_reset();
    final_report();
  end

  initial begin
    #100000;
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
endmodule : fault_reset_event_select_tb
`default_nettype wire
